// *** hw/srr_responder.v ***
// settings report responder: request parser and framed report sender
`timescale 1ns/1ps
`default_nettype none
`include "srr_defs.vh"

module srr_responder (
   input  wire       i_clk_sys,
   input  wire       i_nrst,
   input  wire [7:0] i_rx_data,
   input  wire       i_rx_valid,
   input  wire [7:0] i_load_data,
   input  wire       i_load_valid,
   input  wire       i_load_fld_end,
   input  wire       i_load_clear,
   input  wire       i_tx_ready,
   output reg  [7:0] o_tx_data,
   output reg        o_tx_valid,
   output reg        o_busy,
   output reg        o_load_ready
);

   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_NAME = 7'h02;
   localparam [6:0] ST_CCNT = 7'h04;
   localparam [6:0] ST_FCNT = 7'h08;
   localparam [6:0] ST_STX  = 7'h10;
   localparam [6:0] ST_BODY = 7'h20;
   localparam [6:0] ST_ETX  = 7'h40;

   reg  [7:0] body_mem [0:`SRR_BODY_DEPTH-1];
   reg  [7:0] body_len;
   reg  [6:0] fld_cnt;
   reg  [7:0] rx_hist [0:3];
   reg  [6:0] state;
   reg  [7:0] idx;
   reg        last_sent;
   reg  [6:0] next_state;
   reg  [7:0] next_idx;
   reg  [7:0] next_byte;
   reg        next_last;
   wire [3:0] char_hit;
   wire       req_hit;
   wire       adv;
   wire       load_ok;

   // decimal digit of a count as an ascii character
   function [7:0] srr_digit;
      input [7:0] val;
      input [1:0] pos;
      reg   [7:0] d;
      begin
         d = 8'h00;
         case (pos)
            2'h2:    d = val / 8'd100;
            2'h1:    d = (val / 8'd10) % 8'd10;
            default: d = val % 8'd10;
         endcase
         srr_digit = `SRR_ASCII_ZERO + d;
      end
   endfunction

   // expected request character at a position
   function [7:0] srr_req_char;
      input [1:0] pos;
      begin
         case (pos)
            2'h0:    srr_req_char = `SRR_REQ_C0;
            2'h1:    srr_req_char = `SRR_REQ_C1;
            2'h2:    srr_req_char = `SRR_REQ_C2;
            default: srr_req_char = `SRR_REQ_C3;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_match
         assign char_hit[g] = (rx_hist[g] == srr_req_char(g[1:0]));
      end
   endgenerate

   // R1 - request plus carriage return
   assign req_hit = i_rx_valid && (i_rx_data == `SRR_CR) && (&char_hit);

   // a byte is handed over when the slot is empty or being taken
   assign adv = (state != ST_IDLE) && (!o_tx_valid || i_tx_ready);

   // body is frozen while a report is in flight
   assign load_ok = (state == ST_IDLE) && (body_len != `SRR_BODY_MAX);

   // receive history; a terminator restarts matching
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         rx_hist[0] <= 8'h00;
         rx_hist[1] <= 8'h00;
         rx_hist[2] <= 8'h00;
         rx_hist[3] <= 8'h00;
      end else if (i_rx_valid) begin
         if (i_rx_data == `SRR_CR) begin
            rx_hist[0] <= 8'h00;
            rx_hist[1] <= 8'h00;
            rx_hist[2] <= 8'h00;
            rx_hist[3] <= 8'h00;
         end else begin
            rx_hist[0] <= rx_hist[1];
            rx_hist[1] <= rx_hist[2];
            rx_hist[2] <= rx_hist[3];
            rx_hist[3] <= i_rx_data;
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (load_ok && i_load_valid && !i_load_clear) begin
         body_mem[body_len] <= i_load_data;
      end
   end

   // R2 - length and field count follow the loaded body
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         body_len <= 8'h00;
         fld_cnt  <= 7'h00;
      end else if (state == ST_IDLE && i_load_clear) begin
         body_len <= 8'h00;
         fld_cnt  <= 7'h00;
      end else if (load_ok && i_load_valid) begin
         body_len <= body_len + 8'h01;
         // two digits only, so the count saturates
         if (i_load_fld_end && fld_cnt != `SRR_FLD_MAX) begin
            fld_cnt <= fld_cnt + 7'h01;
         end
      end
   end

   always @* begin
      next_state = state;
      next_idx   = idx + 8'h01;
      next_byte  = 8'h00;
      next_last  = 1'b0;
      case (state)
         ST_NAME: begin
            // R7 - request name first
            next_byte = srr_req_char(idx[1:0]);
            if (idx[1:0] == `SRR_NAME_LEN) begin
               next_state = ST_CCNT;
               next_idx   = 8'h00;
            end
         end
         ST_CCNT: begin
            // R3 - hundreds, tens, units
            next_byte = srr_digit(body_len, `SRR_CCNT_LEN - idx[1:0]);
            if (idx[1:0] == `SRR_CCNT_LEN) begin
               next_state = ST_FCNT;
               next_idx   = 8'h00;
            end
         end
         ST_FCNT: begin
            // R4 - tens, units
            next_byte = srr_digit({1'b0, fld_cnt},
                                  `SRR_FCNT_LEN - idx[1:0]);
            if (idx[1:0] == `SRR_FCNT_LEN) begin
               next_state = ST_STX;
               next_idx   = 8'h00;
            end
         end
         ST_STX: begin
            // R5 - start code ahead of data
            next_byte  = `SRR_STX;
            next_idx   = 8'h00;
            next_state = (body_len == 8'h00) ? ST_ETX : ST_BODY;
         end
         ST_BODY: begin
            next_byte = body_mem[idx];
            if (idx == body_len - 8'h01) begin
               next_state = ST_ETX;
               next_idx   = 8'h00;
            end
         end
         ST_ETX: begin
            // R6 - stop code closes the report
            next_byte  = `SRR_ETX;
            next_last  = 1'b1;
            next_idx   = 8'h00;
         end
         default: begin
            next_idx = 8'h00;
         end
      endcase
   end

   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state        <= ST_IDLE;
         idx          <= 8'h00;
         last_sent    <= 1'b0;
         o_tx_data    <= 8'h00;
         o_tx_valid   <= 1'b0;
         o_busy       <= 1'b0;
         o_load_ready <= 1'b1;
      end else begin
         o_load_ready <= (state == ST_IDLE) && !req_hit &&
                         (body_len != `SRR_BODY_MAX);
         if (state == ST_IDLE) begin
            // requests during a report are dropped, not queued
            if (req_hit) begin
               state        <= ST_NAME;
               idx          <= 8'h00;
               o_busy       <= 1'b1;
               o_load_ready <= 1'b0;
            end
         end else if (adv) begin
            if (last_sent) begin
               // stop code was taken; report complete
               state      <= ST_IDLE;
               last_sent  <= 1'b0;
               o_tx_valid <= 1'b0;
               o_busy     <= 1'b0;
            end else begin
               o_tx_data  <= next_byte;
               o_tx_valid <= 1'b1;
               last_sent  <= next_last;
               state      <= next_state;
               idx        <= next_idx;
            end
         end
      end
   end

endmodule // srr_responder

`default_nettype wire

// *** include/srr_defs.vh ***
// constants for the settings report responder
// Function
// R1 - request then carriage return starts report
// R2 - reply length varies with loaded content
// R3 - second field: three-digit body character count
// R4 - third field: two-digit body field count
// R5 - fourth field: start-of-text before data
// R6 - end-of-text is the last character
// R7 - first field names the answered request
`ifndef SRR_DEFS_VH
`define SRR_DEFS_VH

// request characters and terminator
`define SRR_REQ_C0       8'h4e
`define SRR_REQ_C1       8'h50
`define SRR_REQ_C2       8'h56
`define SRR_REQ_C3       8'h53
`define SRR_CR           8'h0d

// framing codes and ascii digit base
`define SRR_STX          8'h02
`define SRR_ETX          8'h03
`define SRR_ASCII_ZERO   8'h30

// last character index of each field, one less than its width in characters
`define SRR_NAME_LEN     2'h3
`define SRR_CCNT_LEN     2'h2
`define SRR_FCNT_LEN     2'h1

// body store
`define SRR_BODY_DEPTH   256
`define SRR_BODY_MAX     8'hff
`define SRR_FLD_MAX      7'h63

`endif

// *** dv/srr_props.sv ***
// port checker for the report responder
`timescale 1ns/1ps
`default_nettype none
module srr_props (
   input wire logic       i_clk_sys,
   input wire logic       i_nrst,
   input wire logic [7:0] i_rx_data,
   input wire logic       i_rx_valid,
   input wire logic       i_tx_ready,
   input wire logic [7:0] o_tx_data,
   input wire logic       o_tx_valid,
   input wire logic       o_busy,
   input wire logic       o_load_ready
);
   logic [3:0] cnt;
   wire        acc = o_tx_valid && i_tx_ready;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // bytes taken in this report, saturating at 15
   always @(posedge i_clk_sys)
      cnt <= !o_busy ? 4'h0 : cnt + {3'h0, acc && cnt != 4'hf};
   busy_cause_a:
      assert property ($rose(o_busy) |->
         $past(i_rx_valid && i_rx_data == 8'h0d))
      else $error("busy without cr");
   name_first_a:
      assert property ($rose(o_busy) |=> o_tx_valid && o_tx_data == 8'h4e)
      else $error("name byte");
   count_digit_a:
      assert property (acc && cnt > 3 && cnt < 9 |->
         o_tx_data inside {[8'h30:8'h39]}) else $error("count digit");
   start_code_a:
      assert property (acc && cnt == 9 |-> o_tx_data == 8'h02)
      else $error("start code");
   stop_last_a:
      assert property (acc && cnt > 9 && o_tx_data == 8'h03 |=>
         !o_tx_valid && !o_busy) else $error("stop not last");
   hold_out_a:
      assert property (o_tx_valid && !i_tx_ready |=>
         o_tx_valid && $stable(o_tx_data)) else $error("byte moved");
   valid_busy_a:
      assert property (o_tx_valid |-> o_busy) else $error("idle send");
   load_block_a:
      assert property (o_busy |-> !o_load_ready) else $error("load in report");
endmodule // srr_props
`default_nettype wire

// *** dv/srr_host.sv ***
// host model: prompt or slow acceptance, captures the reply
`timescale 1ns/1ps
`default_nettype none
module srr_host (
   input  wire logic       i_clk_sys,
   input  wire logic       i_slow,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_valid,
   output var  logic       o_tx_ready
);
   logic [7:0] got [$];
   initial o_tx_ready = 1'b0;
   always @(negedge i_clk_sys)
      o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
   // take every byte through the stop code
   always @(posedge i_clk_sys)
      if (i_tx_valid && o_tx_ready)
         got.push_back(i_tx_data);
endmodule // srr_host
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the report responder
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       i_clk_sys, i_nrst, i_rx_valid, i_load_valid, i_load_clear;
   logic       i_load_fld_end, slow, tx_ready, tx_valid, busy, load_ready;
   logic [7:0] i_rx_data, i_load_data, tx_data;
   logic [7:0] exp_q [$], body_q [$];
   int         fail_count, cmp_count;
   srr_responder dut (.i_clk_sys, .i_nrst, .i_rx_data, .i_rx_valid,
      .i_load_data, .i_load_valid, .i_load_fld_end, .i_load_clear,
      .i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_tx_valid(tx_valid),
      .o_busy(busy), .o_load_ready(load_ready));
   srr_host host (.i_clk_sys, .i_slow(slow), .i_tx_data(tx_data),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));
   task automatic check(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("fails %0d of %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // characters back to back, closed by cr
   task automatic req(input logic [7:0] c);
      logic [7:0] s [5] = '{8'h4e, 8'h50, c, 8'h53, 8'h0d};
      foreach (s[i]) begin
         @(negedge i_clk_sys);
         i_rx_data = s[i];
         i_rx_valid = 1'b1;
      end
      @(negedge i_clk_sys);
      i_rx_valid = 1'b0;
   endtask
   task automatic report(input int f);
      int n = body_q.size();
      int k = 0;
      exp_q = {8'h4e, 8'h50, 8'h56, 8'h53, 8'(8'h30 + n / 100),
         8'(8'h30 + n / 10 % 10), 8'(8'h30 + n % 10), 8'(8'h30 + f / 10),
         8'(8'h30 + f % 10), 8'h02, body_q, 8'h03};
      host.got.delete();
      req(8'h56);
      check({7'h0, load_ready}, 8'h00);
      // a load and a repeated request during the report are both dropped
      {i_load_valid, i_load_data} = 9'h17e;
      req(8'h56);
      i_load_valid = 1'b0;
      while (busy !== 1'b0 && k < 3000) begin
         @(negedge i_clk_sys);
         k++;
      end
      check({7'h0, k < 3000}, 8'h01);
      check({7'h0, tx_valid}, 8'h00);
      @(negedge i_clk_sys);
      check({7'h0, busy}, 8'h00);
      check({7'h0, load_ready}, 8'h01);
      check(8'(host.got.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) check(host.got[i], exp_q[i]);
   endtask
   // three-digit length, field count held at 99, stalling sink
   task automatic t_big;
      for (int i = 0; i < 105; i++) begin
         @(negedge i_clk_sys);
         {i_load_valid, i_load_fld_end, slow} = 3'h7;
         i_load_data = 8'h41 + 8'(i % 26);
         body_q.push_back(i_load_data);
      end
      @(negedge i_clk_sys);
      i_load_valid = 1'b0;
      report(99);
   endtask
   task automatic t_bad;
      req(8'h58);
      repeat (4) @(negedge i_clk_sys);
      check({7'h0, busy}, 8'h00);
   endtask
   // emptied body still framed, prompt sink; clear beats a load
   task automatic t_clear;
      {i_load_clear, i_load_valid, slow} = 3'h6;
      @(negedge i_clk_sys);
      {i_load_clear, i_load_valid} = 2'h0;
      body_q.delete();
      report(0);
   endtask
   // field count apart from character count
   task automatic t_mixed;
      for (int i = 0; i < 4; i++) begin
         @(negedge i_clk_sys);
         {i_load_valid, i_load_fld_end} = {1'b1, i[0]};
         i_load_data = 8'h61 + 8'(i);
         body_q.push_back(i_load_data);
      end
      @(negedge i_clk_sys);
      i_load_valid = 1'b0;
      report(2);
   endtask
   initial begin
      {i_nrst, i_rx_valid, i_load_valid, i_load_clear, i_load_fld_end} = '0;
      {i_rx_data, i_load_data, slow} = '0;
      repeat (20) @(negedge i_clk_sys);
      i_nrst = 1'b1;
      t_big;
      t_bad;
      t_clear;
      t_mixed;
      final_report;
   end
   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #100us;
      fail_count++;
      final_report;
   end
endmodule // tb
bind srr_responder srr_props chk (.i_clk_sys, .i_nrst, .i_rx_data,
   .i_rx_valid, .i_tx_ready, .o_tx_data, .o_tx_valid, .o_busy,
   .o_load_ready);
`default_nettype wire
